//--- uart_status_consts.svh
// Purpose: offsets, field positions, reset values and counts of the fifo status block
// Assumes: 32-bit APB data, byte addresses as printed
// Notes:   every figure used by more than one file lives here
`ifndef UART_STATUS_CONSTS_SVH
`define UART_STATUS_CONSTS_SVH

// register byte addresses
`define OFS_FIFO_STATUS      32'h5000_117C
`define OFS_TX_FILL_LEVEL    32'h5000_1180
`define OFS_RX_FILL_LEVEL    32'h5000_1184
`define OFS_SOFT_RESET       32'h5000_1188
`define OFS_SEND_REQUEST     32'h5000_118C
`define OFS_QUEUE_CONTROL    32'h5000_11F0
`define OFS_MODEM_CONTROL    32'h5000_11F4
`define OFS_RX_TRIGGER       32'h5000_11F8

// serial_fifo_status fields
`define STAT_RX_FULL_BIT     4
`define STAT_RX_NEMPTY_BIT   3
`define STAT_TX_EMPTY_BIT    2
`define STAT_TX_NFULL_BIT    1

// software_reset_strobes fields
`define SRR_TX_CLEAR_BIT     2
`define SRR_RX_CLEAR_BIT     1
`define SRR_CORE_BIT         0

// shadow_send_request field
`define SRTS_REQUEST_BIT     0

// queue_control_register fields
`define QCR_ENABLE_BIT       0
`define QCR_RX_CLEAR_BIT     1
`define QCR_TX_CLEAR_BIT     2

// modem_control_register fields
`define MCR_REQUEST_BIT      1
`define MCR_LOOPBACK_BIT     4
`define MCR_AUTO_FLOW_BIT    5

// sizes and reset values
`define FIFO_DEPTH_DEFAULT   16
`define LEVEL_W              16
`define RX_TRIGGER_RESET     16'h000E
`define SOFT_RST_HOLD        2

`endif

//--- uart_status_pkg.sv
// Purpose: types shared by the fifo status block
// Assumes: constants come from uart_status_consts.svh
// Notes:   no constants of its own
`include "uart_status_consts.svh"

package uart_status_pkg;

   typedef logic [31:0] word_t;
   typedef logic [`LEVEL_W-1:0] level_t;

   // one queue's activity in one cycle
   typedef struct packed {
      logic push;
      logic pop;
   } queue_evt_s;

   typedef struct packed {
      level_t count;
   } level_state_s;

   typedef struct packed {
      logic [`SOFT_RST_HOLD-1:0] hold;
   } soft_rst_state_s;

   typedef struct packed {
      word_t  prdata;
      logic   pslverr;
      logic   fifo_en;
      logic   rts;
      logic   loopback;
      logic   auto_flow;
      level_t rx_trigger;
      logic   rts_n;
      logic   loop_cts;
   } ctrl_state_s;

endpackage

//--- queue_level_tracker.sv
// Purpose: fill level, full and empty of one data queue
// Assumes: push and pop come from the serial core, one entry each
// Notes:   clear wins over any event; push when full without a pop and pop when empty are dropped
`include "uart_status_consts.svh"

module queue_level_tracker #(
   parameter int DEPTH = `FIFO_DEPTH_DEFAULT
) (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        clear,
   input  wire uart_status_pkg::queue_evt_s evt,
   output      uart_status_pkg::level_t     level,
   output      logic                        full,
   output      logic                        empty
);

   localparam uart_status_pkg::level_t TOP = `LEVEL_W'(DEPTH);

   uart_status_pkg::level_state_s st;
   uart_status_pkg::level_state_s next_st;

   logic do_push;
   logic do_pop;

   always_comb
   begin
      do_push = evt.push & ((st.count != TOP) | evt.pop);
      do_pop  = evt.pop & (st.count != '0);
      next_st = st;
      if (do_push & ~do_pop)
      begin
         next_st.count = st.count + 16'h0001;
      end
      else if (do_pop & ~do_push)
      begin
         next_st.count = st.count - 16'h0001;
      end
      if (rst | clear)
      begin
         next_st.count = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      st <= next_st;
   end

   assign level = st.count;
   assign full  = (st.count == TOP);
   assign empty = (st.count == '0);

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   level_bound_a: assert property (st.count <= TOP)
      else $error("fill level above queue depth");
   full_hold_a: assert property (full && evt.push && !evt.pop && !clear |=> full)
      else $error("push into full queue changed level");

endmodule

//--- soft_reset_gen.sv
// Purpose: core reset from a one-cycle software request
// Assumes: request is a pulse in the register clock domain
// Notes:   asserts in the request cycle itself, releases on a clock edge
`include "uart_status_consts.svh"

module soft_reset_gen (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic request,
   output      logic core_rst
);

   uart_status_pkg::soft_rst_state_s st;
   uart_status_pkg::soft_rst_state_s next_st;

   always_comb
   begin
      next_st.hold = {st.hold[`SOFT_RST_HOLD-2:0], request};
      if (rst)
      begin
         next_st.hold = '0;
      end
   end

   always_ff @(posedge clk)
   begin
      st <= next_st;
   end

   // combinational assertion, clocked release
   assign core_rst = request | (|st.hold);

endmodule

//--- uart_fifo_status_and_shadow_ctrl.sv
// Purpose: fifo status, fill levels, clear strobes, core reset and send-request control
// Assumes: APB slave with no wait states; queue events synchronous to REF_CLK
// Notes:   read data is captured in the setup cycle; RTS_N follows control one cycle later
// How it works
// - status bit 4 reads 1 while every receive entry is occupied
// - status bit 3 reads 1 while the receive queue holds an entry
// - status bit 2 reads 1 only with an empty transmit queue; resets to 1
// - status bit 1 reads 0 only with a full transmit queue; resets to 1
// - transmit level register shows the transmit entry count, zero at reset
// - receive level register shows the receive entry count, zero at reset
// - soft reset bit 2 clears the transmit queue like the queue control bit
// - a queue clear empties the queue and needs no second write
// - soft reset bit 1 clears the receive queue like the queue control bit
// - soft reset bit 0 asserts core reset at once, releases on a clock edge
// - send request bit 0 shares storage with modem control request bit
// - without auto flow or loopback, RTS_N is the inverse of the request bit
// - with auto flow and queues on, receive level above trigger forces RTS_N high
// - loopback holds RTS_N high and loops the request bit to the modem input
// - queue depth is a parameter, default 16, bounding levels and full flags
// - turning the queue enable off clears both queues
//
// The implementer's own choice: the APB interface to the registers.
`include "uart_status_consts.svh"

module uart_fifo_status_and_shadow_ctrl #(
   parameter int FIFO_DEPTH = `FIFO_DEPTH_DEFAULT
) (
   input  wire logic                        REF_CLK,
   input  wire logic                        SYS_RST,
   input  wire logic                        PSEL,
   input  wire logic                        PENABLE,
   input  wire logic                        PWRITE,
   input  wire logic [31:0]                 PADDR,
   input  wire logic [31:0]                 PWDATA,
   output      logic [31:0]                 PRDATA,
   output      logic                        PREADY,
   output      logic                        PSLVERR,
   input  wire uart_status_pkg::queue_evt_s TX_EVT,
   input  wire uart_status_pkg::queue_evt_s RX_EVT,
   output      logic                        TX_QUEUE_CLEAR,
   output      logic                        RX_QUEUE_CLEAR,
   output      logic                        CORE_RST,
   output      logic                        FIFO_ENABLE,
   output      logic                        RTS_N,
   output      logic                        LOOP_CTS
);

   uart_status_pkg::ctrl_state_s st;
   uart_status_pkg::ctrl_state_s next_st;

   uart_status_pkg::level_t tx_level;
   uart_status_pkg::level_t rx_level;
   uart_status_pkg::word_t  rd_word;

   logic tx_full;
   logic tx_empty;
   logic rx_full;
   logic rx_empty;
   logic setup;
   logic wr;
   logic hit_status;
   logic hit_tfl;
   logic hit_rfl;
   logic hit_srr;
   logic hit_srts;
   logic hit_qcr;
   logic hit_mcr;
   logic hit_trig;
   logic mapped;
   logic enable_fall;
   logic core_request;
   logic core_rst;
   logic any_rst;
   logic rx_over_trigger;

   // address decode, full byte address
   always_comb
   begin
      hit_status = (PADDR == `OFS_FIFO_STATUS);
      hit_tfl    = (PADDR == `OFS_TX_FILL_LEVEL);
      hit_rfl    = (PADDR == `OFS_RX_FILL_LEVEL);
      hit_srr    = (PADDR == `OFS_SOFT_RESET);
      hit_srts   = (PADDR == `OFS_SEND_REQUEST);
      hit_qcr    = (PADDR == `OFS_QUEUE_CONTROL);
      hit_mcr    = (PADDR == `OFS_MODEM_CONTROL);
      hit_trig   = (PADDR == `OFS_RX_TRIGGER);
      mapped     = hit_status | hit_tfl | hit_rfl | hit_srr | hit_srts
                   | hit_qcr | hit_mcr | hit_trig;
   end

   assign setup = PSEL & ~PENABLE;
   assign wr    = PSEL & PENABLE & PWRITE;

   // strobes act on the access edge, clear themselves afterwards
   assign core_request   = wr & hit_srr & PWDATA[`SRR_CORE_BIT];
   assign enable_fall    = wr & hit_qcr & st.fifo_en & ~PWDATA[`QCR_ENABLE_BIT];
   assign TX_QUEUE_CLEAR = core_rst | enable_fall
                           | (wr & hit_srr & PWDATA[`SRR_TX_CLEAR_BIT])
                           | (wr & hit_qcr & PWDATA[`QCR_TX_CLEAR_BIT]);
   assign RX_QUEUE_CLEAR = core_rst | enable_fall
                           | (wr & hit_srr & PWDATA[`SRR_RX_CLEAR_BIT])
                           | (wr & hit_qcr & PWDATA[`QCR_RX_CLEAR_BIT]);
   assign any_rst        = SYS_RST | core_rst;

   soft_reset_gen u_soft_reset (
      .clk      (REF_CLK),
      .rst      (SYS_RST),
      .request  (core_request),
      .core_rst (core_rst)
   );

   queue_level_tracker #(
      .DEPTH (FIFO_DEPTH)
   ) u_tx_level (
      .clk   (REF_CLK),
      .rst   (SYS_RST),
      .clear (TX_QUEUE_CLEAR),
      .evt   (TX_EVT),
      .level (tx_level),
      .full  (tx_full),
      .empty (tx_empty)
   );

   queue_level_tracker #(
      .DEPTH (FIFO_DEPTH)
   ) u_rx_level (
      .clk   (REF_CLK),
      .rst   (SYS_RST),
      .clear (RX_QUEUE_CLEAR),
      .evt   (RX_EVT),
      .level (rx_level),
      .full  (rx_full),
      .empty (rx_empty)
   );

   // read mux; unlisted bits stay zero
   always_comb
   begin
      rd_word = '0;
      if (hit_status)
      begin
         rd_word[`STAT_RX_FULL_BIT]   = rx_full;
         rd_word[`STAT_RX_NEMPTY_BIT] = ~rx_empty;
         rd_word[`STAT_TX_EMPTY_BIT]  = tx_empty;
         rd_word[`STAT_TX_NFULL_BIT]  = ~tx_full;
      end
      else if (hit_tfl)
      begin
         rd_word[`LEVEL_W-1:0] = tx_level;
      end
      else if (hit_rfl)
      begin
         rd_word[`LEVEL_W-1:0] = rx_level;
      end
      else if (hit_srts)
      begin
         rd_word[`SRTS_REQUEST_BIT] = st.rts;
      end
      else if (hit_qcr)
      begin
         rd_word[`QCR_ENABLE_BIT] = st.fifo_en;
      end
      else if (hit_mcr)
      begin
         rd_word[`MCR_REQUEST_BIT]   = st.rts;
         rd_word[`MCR_LOOPBACK_BIT]  = st.loopback;
         rd_word[`MCR_AUTO_FLOW_BIT] = st.auto_flow;
      end
      else if (hit_trig)
      begin
         rd_word[`LEVEL_W-1:0] = st.rx_trigger;
      end
      // the soft reset register falls through and reads zero
   end

   assign rx_over_trigger = rx_level > st.rx_trigger;

   always_comb
   begin
      next_st = st;
      if (setup)
      begin
         next_st.prdata  = rd_word;
         next_st.pslverr = ~mapped;
      end
      if (wr & hit_qcr)
      begin
         next_st.fifo_en = PWDATA[`QCR_ENABLE_BIT];
      end
      if (wr & hit_mcr)
      begin
         next_st.rts       = PWDATA[`MCR_REQUEST_BIT];
         next_st.loopback  = PWDATA[`MCR_LOOPBACK_BIT];
         next_st.auto_flow = PWDATA[`MCR_AUTO_FLOW_BIT];
      end
      if (wr & hit_srts)
      begin
         next_st.rts = PWDATA[`SRTS_REQUEST_BIT];
      end
      if (wr & hit_trig)
      begin
         next_st.rx_trigger = PWDATA[`LEVEL_W-1:0];
      end
      // low RTS_N tells the modem the port is ready
      if (st.loopback)
      begin
         next_st.rts_n = 1'b1;
      end
      else if (st.auto_flow & st.fifo_en & rx_over_trigger)
      begin
         next_st.rts_n = 1'b1;
      end
      else
      begin
         next_st.rts_n = ~st.rts;
      end
      next_st.loop_cts = st.loopback & st.rts;
      if (any_rst)
      begin
         next_st            = '0;
         next_st.rts_n      = 1'b1;
         next_st.rx_trigger = `RX_TRIGGER_RESET;
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      st <= next_st;
   end

   assign PRDATA      = st.prdata;
   assign PSLVERR     = st.pslverr & PSEL & PENABLE;
   assign PREADY      = 1'b1;
   assign CORE_RST    = core_rst;
   assign FIFO_ENABLE = st.fifo_en;
   assign RTS_N       = st.rts_n;
   assign LOOP_CTS    = st.loop_cts;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);

   // read checks look one cycle after the setup cycle that loads PRDATA
   rx_full_read_a: assert property (setup && hit_status |=> PRDATA[4] == $past(rx_full))
      else $error("status read lost receive full flag");
   rx_nempty_read_a: assert property (setup && hit_status |=>
      PRDATA[3] == ($past(rx_level) != 16'h0000))
      else $error("status read lost receive not empty flag");
   tx_empty_read_a: assert property (setup && hit_status |=>
      PRDATA[2] == ($past(tx_level) == 16'h0000))
      else $error("status read lost transmit empty flag");
   tx_nfull_read_a: assert property (setup && hit_status |=>
      PRDATA[1] == ($past(tx_level) != 16'(FIFO_DEPTH)))
      else $error("status read lost transmit not full flag");
   tx_level_read_a: assert property (setup && hit_tfl |=> PRDATA == {16'h0000, $past(tx_level)})
      else $error("transmit level read wrong");
   rx_level_read_a: assert property (setup && hit_rfl |=> PRDATA == {16'h0000, $past(rx_level)})
      else $error("receive level read wrong");
   tx_clear_srr_a: assert property (wr && hit_srr && PWDATA[2] |=> tx_level == 16'h0000)
      else $error("transmit clear strobe did not empty queue");
   clear_self_a: assert property (wr && hit_srr && PWDATA[2] && !core_rst ##1 !wr
      |-> !TX_QUEUE_CLEAR || enable_fall)
      else $error("transmit clear did not self clear");
   rx_clear_srr_a: assert property (wr && hit_srr && PWDATA[1] |=> rx_level == 16'h0000)
      else $error("receive clear strobe did not empty queue");
   core_reset_a: assert property (core_request |-> CORE_RST ##1 CORE_RST ##1
      (CORE_RST && !FIFO_ENABLE && RTS_N))
      else $error("core reset not asserted and held");
   shadow_share_a: assert property (wr && hit_srts && !any_rst |=>
      st.rts == $past(PWDATA[0]))
      else $error("shadow send request not shared with modem control");
   rts_direct_a: assert property (!st.loopback && !st.auto_flow && !any_rst |=>
      RTS_N == !$past(st.rts))
      else $error("RTS_N does not follow request bit");
   rts_flow_a: assert property (st.auto_flow && st.fifo_en && rx_over_trigger && !any_rst
      |=> RTS_N)
      else $error("RTS_N not forced high above trigger");
   loop_hold_a: assert property (st.loopback && !any_rst |=> RTS_N && LOOP_CTS == $past(st.rts))
      else $error("loopback did not hold RTS_N and loop request");
   enable_off_a: assert property (enable_fall |=> tx_level == 16'h0000 && rx_level == 16'h0000)
      else $error("disabling queues did not clear them");
   reserved_read_a: assert property (setup && hit_status |=> PRDATA[31:5] == '0 && !PRDATA[0])
      else $error("reserved status bits not zero");
   srr_read_a: assert property (setup && hit_srr |=> PRDATA == 32'h0000_0000)
      else $error("soft reset register did not read zero");
   qcr_tx_clear_a: assert property (wr && hit_qcr && PWDATA[2] |=> tx_level == 16'h0000)
      else $error("queue control transmit clear did not empty queue");
   qcr_rx_clear_a: assert property (wr && hit_qcr && PWDATA[1] |=> rx_level == 16'h0000)
      else $error("queue control receive clear did not empty queue");
   core_rst_state_a: assert property (any_rst |=> RTS_N && !LOOP_CTS && !FIFO_ENABLE)
      else $error("core reset left control state set");
   level_ro_a: assert property (wr && hit_tfl && !TX_QUEUE_CLEAR && TX_EVT == '0 |=>
      tx_level == $past(tx_level))
      else $error("write to transmit level register changed it");

   tx_full_c: cover property (tx_full && TX_EVT.push);
   flow_stop_c: cover property (st.auto_flow && st.fifo_en && rx_over_trigger && st.rts);
   soft_reset_c: cover property (core_request);
   loopback_c: cover property (st.loopback && st.rts ##1 LOOP_CTS);
   enable_off_c: cover property (enable_fall);

endmodule

//--- modem_partner.sv
// Purpose: modem model on the send-request line, feeding receive entries
// Assumes: RTS_N low means the port is ready to exchange data
// Notes:   at most one entry per cycle, each pushed the cycle after RTS_N is sampled low
module modem_partner (
   input  wire logic                        clk,
   input  wire logic                        rts_n,
   input  wire logic [7:0]                  budget,
   input  wire logic                        load,
   output      uart_status_pkg::queue_evt_s rx_evt,
   output      logic [7:0]                  left
);
   timeunit 1ns;
   timeprecision 1ps;
   logic send;
   assign send = (left != 8'h00) && (rts_n == 1'b0);
   always_ff @(posedge clk)
   begin
      rx_evt.pop <= 1'b0;
      if (load)
      begin
         left        <= budget;
         rx_evt.push <= 1'b0;
      end
      else
      begin
         rx_evt.push <= send;
         if (send)
            left <= left - 8'h01;
      end
   end
endmodule

//--- testbench.sv
// Purpose: self-checking bench of the fifo status and send-request block
// Assumes: APB master waits for pready; queue events driven on clock edges
// Notes:   ordinary register cases in a table, awkward cases written out after
`include "uart_status_consts.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e;} row_s;
   logic                        clk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic                        tx_clr, rx_clr, core_rst, fifo_en, rts_n, loop_cts, load;
   logic [31:0]                 paddr, pwdata, prdata, rd;
   logic                        er, cr, tc, rc;
   logic [7:0]                  budget, left;
   uart_status_pkg::queue_evt_s tx_evt, rx_evt;
   int                          num_errors, num_checks, i, n;
   row_s                        rows [11];

   uart_fifo_status_and_shadow_ctrl u_dut (.REF_CLK(clk), .SYS_RST(sys_rst), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .TX_EVT(tx_evt), .RX_EVT(rx_evt),
      .TX_QUEUE_CLEAR(tx_clr), .RX_QUEUE_CLEAR(rx_clr), .CORE_RST(core_rst),
      .FIFO_ENABLE(fifo_en), .RTS_N(rts_n), .LOOP_CTS(loop_cts));
   modem_partner u_modem (.clk(clk), .rts_n(rts_n), .budget(budget), .load(load),
      .rx_evt(rx_evt), .left(left));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask

   // one transfer, then one idle cycle so the next setup never collides
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
      begin
         @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      cr = core_rst;
      tc = tx_clr;
      rc = rx_clr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rd);
   endtask

   task automatic txq(input logic p, input logic q, input int cnt);
      tx_evt <= '{push: p, pop: q};
      repeat (cnt) @(posedge clk);
      tx_evt <= '0;
      @(posedge clk);
   endtask

   task automatic feed(input logic [7:0] b);
      budget <= b;
      load   <= 1'b1;
      @(posedge clk);
      load   <= 1'b0;
      @(posedge clk);
   endtask

   task automatic drain();
      n = 0;
      while (left !== 8'h00 && n < 100)
      begin
         @(posedge clk);
         n++;
      end
      repeat (3) @(posedge clk);
   endtask

   initial
   begin
      repeat (5000) @(posedge clk);
      num_errors++;
      summarize();
   end

   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, budget} = '0;
      tx_evt = '0;
      sys_rst = 1'b1;
      load = 1'b1;
      rows = '{'{0, `OFS_FIFO_STATUS, 0, 32'h0000_0006}, '{0, `OFS_TX_FILL_LEVEL, 0, 0},
         '{0, `OFS_RX_FILL_LEVEL, 0, 0}, '{0, `OFS_SOFT_RESET, 0, 0},
         '{0, `OFS_SEND_REQUEST, 0, 0}, '{1, `OFS_SEND_REQUEST, 32'h0000_FFFF, 0},
         '{0, `OFS_SEND_REQUEST, 0, 32'h0000_0001}, '{1, `OFS_FIFO_STATUS, 32'hFFFF_FFFF, 0},
         '{0, `OFS_FIFO_STATUS, 0, 32'h0000_0006}, '{1, `OFS_TX_FILL_LEVEL, 32'h0000_0007, 0},
         '{0, `OFS_TX_FILL_LEVEL, 0, 0}};
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      load    <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 11; i++)
      begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w)
            chk("table read", rows[i].e, rd);
      end
      apb(1'b0, `OFS_SEND_REQUEST + 32'h0000_0004, 0);
      chk("unmapped error", 1, er);
      apb(1'b1, `OFS_MODEM_CONTROL, 0);
      rdc("mirror cleared", `OFS_SEND_REQUEST, 0);
      txq(1'b1, 1'b0, 17);
      rdc("tx level full", `OFS_TX_FILL_LEVEL, 16);
      rdc("status tx full", `OFS_FIFO_STATUS, 0);
      txq(1'b0, 1'b1, 1);
      rdc("status tx part", `OFS_FIFO_STATUS, 32'h0000_0002);
      apb(1'b1, `OFS_SOFT_RESET, 32'h0000_0004);
      chk("tx clear strobe", 1, tc);
      chk("tx strobe self clear", 0, tx_clr);
      rdc("tx level clear", `OFS_TX_FILL_LEVEL, 0);
      rdc("status tx clear", `OFS_FIFO_STATUS, 32'h0000_0006);
      apb(1'b1, `OFS_SEND_REQUEST, 1);
      @(posedge clk);
      chk("rts low", 0, rts_n);
      rdc("request mirror", `OFS_MODEM_CONTROL, 32'h0000_0002);
      feed(20);
      drain();
      rdc("rx level full", `OFS_RX_FILL_LEVEL, 16);
      rdc("status rx full", `OFS_FIFO_STATUS, 32'h0000_001E);
      apb(1'b1, `OFS_MODEM_CONTROL, 0);
      @(posedge clk);
      chk("rts high", 1, rts_n);
      apb(1'b1, `OFS_SOFT_RESET, 32'h0000_0002);
      chk("rx clear strobe", 1, rc);
      rdc("rx level clear", `OFS_RX_FILL_LEVEL, 0);
      rdc("status rx clear", `OFS_FIFO_STATUS, 32'h0000_0006);
      apb(1'b1, `OFS_QUEUE_CONTROL, 1);
      chk("queue enable", 1, fifo_en);
      apb(1'b1, `OFS_RX_TRIGGER, 3);
      feed(12);
      apb(1'b1, `OFS_MODEM_CONTROL, 32'h0000_0022);
      repeat (30) @(posedge clk);
      chk("rts gated", 1, rts_n);
      chk("modem stalled", 1, left != 8'h00);
      feed(0);
      apb(1'b1, `OFS_MODEM_CONTROL, 0);
      txq(1'b1, 1'b0, 3);
      apb(1'b1, `OFS_QUEUE_CONTROL, 0);
      chk("disable strobe", 1, tc);
      chk("queue disabled", 0, fifo_en);
      rdc("tx after disable", `OFS_TX_FILL_LEVEL, 0);
      rdc("rx after disable", `OFS_RX_FILL_LEVEL, 0);
      apb(1'b1, `OFS_MODEM_CONTROL, 32'h0000_0012);
      @(posedge clk);
      chk("loop rts", 1, rts_n);
      chk("loop cts", 1, loop_cts);
      txq(1'b1, 1'b0, 2);
      apb(1'b1, `OFS_SOFT_RESET, 1);
      chk("core reset", 1, cr);
      n = 0;
      while (core_rst !== 1'b0 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      rdc("mirror after reset", `OFS_SEND_REQUEST, 0);
      rdc("tx after reset", `OFS_TX_FILL_LEVEL, 0);
      chk("cts after reset", 0, loop_cts);
      txq(1'b1, 1'b0, 2);
      apb(1'b1, `OFS_QUEUE_CONTROL, 32'h0000_0006);
      chk("control tx strobe", 1, tc);
      chk("control rx strobe", 1, rc);
      rdc("tx after control clear", `OFS_TX_FILL_LEVEL, 0);
      summarize();
   end
endmodule
